/* design/tvcrb_pkg.sv */
// Constants of the television control register bank: bus address, register map, fields, reset values.
// Assumes an I2C master on the two-wire link that writes sub-addressed control bytes.
package tvcrb_pkg;
  localparam logic [6:0] TVCRB_SLAVE_ADDR = 7'h5D;
  localparam int TVCRB_NUM_REGS = 20;
  localparam logic [4:0] TVCRB_LAST_SUB = 5'h13;
  // Sub-addresses
  localparam logic [4:0] SUB_TEST_MUTE_SYNC_CTRL = 5'h00;
  localparam logic [4:0] SUB_HORIZ_LOOP_PHASE = 5'h01;
  localparam logic [4:0] SUB_AGC_AFT_CTRL = 5'h02;
  localparam logic [4:0] SUB_VIDEO_SELECT_VCO_TUNE = 5'h03;
  localparam logic [4:0] SUB_AUDIO_MUTE_CROSSOVER = 5'h04;
  localparam logic [4:0] SUB_VERT_COUNTDOWN_DC = 5'h05;
  localparam logic [4:0] SUB_VERT_KILL_AMPLITUDE = 5'h06;
  localparam logic [4:0] SUB_RED_DC_LEVEL = 5'h07;
  localparam logic [4:0] SUB_GREEN_DC_LEVEL = 5'h08;
  localparam logic [4:0] SUB_BLUE_DC_LEVEL = 5'h09;
  localparam logic [4:0] SUB_BLANKING_RED_GAIN = 5'h0A;
  localparam logic [4:0] SUB_GAIN_TEST_BLUE_GAIN = 5'h0B;
  localparam logic [4:0] SUB_OUTPUT_FORMAT_BRIGHTNESS = 5'h0C;
  localparam logic [4:0] SUB_CONTRAST_SETTING = 5'h0D;
  localparam logic [4:0] SUB_LUMA_FILTER_SHARPNESS = 5'h0E;
  localparam logic [4:0] SUB_HUE_SETTING = 5'h0F;
  localparam logic [4:0] SUB_SATURATION_SETTING = 5'h10;
  localparam logic [4:0] SUB_VERTICAL_TEST_SELECT = 5'h11;
  localparam logic [4:0] SUB_IF_VIDEO_AUDIO_LEVELS = 5'h12;
  localparam logic [4:0] SUB_NOISE_AUDIO_VOLUME = 5'h13;
  // Field positions in the stored byte; DA0 is the most significant bit and arrives first on the wire
  localparam int DA0 = 7;
  localparam int DA1 = 6;
  localparam int DA2 = 5;
  localparam int DA3 = 4;
  localparam int DA4 = 3;
  localparam int DA5 = 2;
  localparam int DA6 = 1;
  localparam int DA7 = 0;
  // Reset image, DA0 in bit 7
  localparam logic [7:0] TVCRB_RESET [TVCRB_NUM_REGS] = '{
    8'h02, 8'h04, 8'h20, 8'h40, 8'h60, 8'h20, 8'h20, 8'h00, 8'h00, 8'h00,
    8'h7F, 8'h7F, 8'h40, 8'h40, 8'h10, 8'h40, 8'h40, 8'h00, 8'h90, 8'h00};
  // Used bits per register; others are ignored
  localparam logic [7:0] TVCRB_USED [TVCRB_NUM_REGS] = '{
    8'h0B, 8'h0F, 8'hFF, 8'hFF, 8'h7F, 8'hBF, 8'hFF, 8'h7F, 8'h7F, 8'h7F,
    8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h07, 8'hFF, 8'hFF};
  // Sync-stage depth for the link-to-core word handover
  localparam int TVCRB_SYNC_STAGES = 2;
endpackage : tvcrb_pkg

/* design/tvcrb_i2c_slave.sv */
// I2C write-only slave on the link clock domain.
// Assumes scl is the link clock port and sda is sampled by it; delivers address/byte pairs by toggle.
`timescale 1ns/1ns
module tvcrb_i2c_slave (
  input wire logic scl,
  input wire logic rst_b,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  output logic [4:0] wr_sub,
  output logic [7:0] wr_data,
  output logic wr_toggle
);
  import tvcrb_pkg::*;

  typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_SUB, ST_DATA, ST_ACK, ST_SKIP} tvcrb_lst_t;

  typedef struct packed {
    tvcrb_lst_t st;
    tvcrb_lst_t after_ack;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic [4:0] sub;
    logic [4:0] wsub;
    logic [7:0] wdat;
    logic tog;
    logic started;
  } tvcrb_link_t;

  tvcrb_link_t s_r;
  tvcrb_link_t s_nxt;
  logic start_seen_r;

  ////////////////////////////////////////////////////////////////////////////////
  // Start detection: toggles only when sda falls while scl is high, so data and ack edges leave it alone
  always_ff @(negedge sda_in or negedge rst_b) begin
    if (!rst_b) begin
      start_seen_r <= 1'b0;
    end else begin
      start_seen_r <= start_seen_r ^ scl;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Bits are taken on rising scl; ack drive held by the falling-edge stage
  always_comb begin
    s_nxt = s_r;
    if (start_seen_r != s_r.started) begin
      s_nxt.started = start_seen_r;
      s_nxt.st = ST_ADDR;
      s_nxt.cnt = 4'h1;
      s_nxt.sh = {7'h00, sda_in};
    end else begin
      unique case (s_r.st)
        ST_IDLE: begin
        end
        ST_ACK: begin
          // The acknowledge clock carries no data; the next byte starts on the following edge
          s_nxt.st = s_r.after_ack;
          s_nxt.cnt = 4'h0;
          s_nxt.sh = 8'h00;
        end
        ST_SKIP: begin
        end
        default: begin
          s_nxt.sh = {s_r.sh[6:0], sda_in};
          s_nxt.cnt = s_r.cnt + 4'h1;
          if (s_r.cnt == 4'h7) begin
            s_nxt.st = ST_ACK;
            if (s_r.st == ST_ADDR) begin
              // Only our address with write direction is answered
              s_nxt.after_ack = (s_r.sh[6:0] == TVCRB_SLAVE_ADDR && !sda_in) ? ST_SUB : ST_SKIP;
              if (s_r.sh[6:0] != TVCRB_SLAVE_ADDR || sda_in) begin
                s_nxt.st = ST_SKIP;
              end
            end else if (s_r.st == ST_SUB) begin
              s_nxt.sub = {s_r.sh[3:0], sda_in};
              s_nxt.after_ack = ST_DATA;
              if ({s_r.sh[6:0], sda_in} > {3'h0, TVCRB_LAST_SUB}) begin
                s_nxt.st = ST_SKIP;
              end
            end else begin
              // DA0 arrives first, so it lands in bit 7 of the stored byte
              s_nxt.wdat = {s_r.sh[6:0], sda_in};
              s_nxt.wsub = s_r.sub;
              s_nxt.tog = ~s_r.tog;
              s_nxt.sub = (s_r.sub == TVCRB_LAST_SUB) ? 5'h00 : s_r.sub + 5'h01;
              s_nxt.after_ack = ST_DATA;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge scl or negedge rst_b) begin
    if (!rst_b) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  logic ack_r;
  always_ff @(negedge scl or negedge rst_b) begin
    if (!rst_b) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= (s_r.st == ST_ACK);
    end
  end

  assign sda_out = 1'b0;
  assign sda_oe = ack_r;
  assign wr_sub = s_r.wsub;
  assign wr_data = s_r.wdat;
  assign wr_toggle = s_r.tog;

  a_ack_only_low: assert property (@(posedge scl) disable iff (!rst_b)
    sda_oe |-> !sda_out) else $error("ack drive must pull low");
  a_sub_in_range: assert property (@(posedge scl) disable iff (!rst_b)
    $changed(wr_toggle) |-> wr_sub <= TVCRB_LAST_SUB) else $error("write to unmapped sub-address");
endmodule : tvcrb_i2c_slave

/* design/tvcrb_top.sv */
// Control register bank: twenty write-only bytes filled over the two-wire link, fanned out as fields.
// Assumes the link clock arrives on scl and the core clock runs at 250 MHz, unrelated in phase.
`timescale 1ns/1ns
// What this block does
// - Answers slave address, accepts sub-addresses 00 to 13, DA0 stored as MSB.
// - Test gate bit: zero enables test mode, one blocks tests and allows video mute.
// - Mutes and kills are active high; auto-flesh on high; stretch defeat high.
// - Horizontal loop speed bit: zero slow, one fast.
// - Three-bit horizontal phase field drives sync-to-flyback alignment.
// - Gain loop defeat and fine-tune output defeat bits, one means defeated.
// - Six-bit tuner gain threshold field.
// - Picture source select bit picks internal or external video.
// - Seven-bit VCO tuning field.
// - Vertical countdown select: zero standard, one non-standard.
// - Six-bit vertical bias, vertical amplitude and crossover trim fields.
// - Seven-bit red, green, blue DC level fields.
// - Blanking off bit: one removes horizontal and vertical blanking.
// - Drive, contrast, tint, color DAC test bits; one selects test mode.
// - Output format bit: zero RGB, one color difference.
// - Luma filter select: zero trap, one all-pass.
// - Three-bit vertical test field; nonzero selects size test.
// - Three-bit IF video level and five-bit wideband sound level.
// - Noise inverter defeat bit: zero active, one defeated.
// - Sound source select bit and six-bit volume field.
// - Seven-bit brightness, seven-bit contrast, five-bit sharpness fields.
module tvcrb_top (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  output logic test_mode_enable,
  output logic video_mute,
  output logic sync_kill,
  output logic horiz_loop_speed,
  output logic [2:0] horiz_phase,
  output logic gain_loop_defeat,
  output logic fine_tune_out_defeat,
  output logic [5:0] tuner_gain_threshold,
  output logic picture_source_select,
  output logic [6:0] vco_tune,
  output logic audio_mute,
  output logic [5:0] crossover_trim,
  output logic vert_countdown_select,
  output logic [5:0] vert_bias_trim,
  output logic vert_kill,
  output logic color_kill,
  output logic [5:0] vert_amplitude,
  output logic [6:0] red_dc,
  output logic [6:0] green_dc,
  output logic [6:0] blue_dc,
  output logic blanking_off,
  output logic [6:0] red_gain,
  output logic drive_test,
  output logic [6:0] blue_gain,
  output logic color_diff_mode,
  output logic [6:0] brightness,
  output logic contrast_test,
  output logic [6:0] contrast,
  output logic luma_filter_select,
  output logic auto_flesh,
  output logic dark_level_expand_defeat,
  output logic [4:0] sharpness,
  output logic tint_test,
  output logic [6:0] tint,
  output logic color_test,
  output logic [6:0] color,
  output logic vert_size_test,
  output logic [2:0] if_video_level,
  output logic [4:0] wideband_sound_level,
  output logic noise_inverter_defeat,
  output logic sound_source_select,
  output logic [5:0] volume
);
  import tvcrb_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // Link side
  logic [4:0] l_sub;
  logic [7:0] l_data;
  logic l_tog;

  tvcrb_i2c_slave u_link (
    .scl(scl),
    .rst_b(rst_b),
    .sda_in(sda_in),
    .sda_out(sda_out),
    .sda_oe(sda_oe),
    .wr_sub(l_sub),
    .wr_data(l_data),
    .wr_toggle(l_tog)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Core state: synchroniser, toggle edge, register image
  typedef struct packed {
    logic tog_s1;
    logic tog_s2;
    logic tog_s3;
    logic [TVCRB_NUM_REGS-1:0][7:0] regs;
  } tvcrb_core_t;

  tvcrb_core_t c_r;
  tvcrb_core_t c_nxt;
  logic take;

  function automatic logic [7:0] reg_of(input tvcrb_core_t c, input logic [4:0] sub);
    reg_of = c.regs[sub];
  endfunction : reg_of

  // Toggle is stable once it flips; sub and data change on the same scl edge and then hold for a full byte
  assign take = c_r.tog_s2 ^ c_r.tog_s3;

  always_comb begin
    c_nxt = c_r;
    c_nxt.tog_s1 = l_tog;
    c_nxt.tog_s2 = c_r.tog_s1;
    c_nxt.tog_s3 = c_r.tog_s2;
    if (take && l_sub <= TVCRB_LAST_SUB) begin
      c_nxt.regs[l_sub] = l_data & TVCRB_USED[l_sub];
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      c_r.tog_s1 <= 1'b0;
      c_r.tog_s2 <= 1'b0;
      c_r.tog_s3 <= 1'b0;
      for (int i = 0; i < TVCRB_NUM_REGS; i++) begin
        c_r.regs[i] <= TVCRB_RESET[i];
      end
    end else begin
      c_r <= c_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Field fan-out; DA0 is bit 7, so a field reads its lowest DA number as its MSB
  logic [7:0] r00;
  logic [7:0] r01;
  logic [7:0] r02;
  logic [7:0] r03;
  logic [7:0] r04;
  logic [7:0] r05;
  logic [7:0] r06;
  logic [7:0] r0a;
  logic [7:0] r0b;
  logic [7:0] r0c;
  logic [7:0] r0d;
  logic [7:0] r0e;
  logic [7:0] r0f;
  logic [7:0] r10;
  logic [7:0] r11;
  logic [7:0] r12;
  logic [7:0] r13;

  assign r00 = reg_of(c_r, SUB_TEST_MUTE_SYNC_CTRL);
  assign r01 = reg_of(c_r, SUB_HORIZ_LOOP_PHASE);
  assign r02 = reg_of(c_r, SUB_AGC_AFT_CTRL);
  assign r03 = reg_of(c_r, SUB_VIDEO_SELECT_VCO_TUNE);
  assign r04 = reg_of(c_r, SUB_AUDIO_MUTE_CROSSOVER);
  assign r05 = reg_of(c_r, SUB_VERT_COUNTDOWN_DC);
  assign r06 = reg_of(c_r, SUB_VERT_KILL_AMPLITUDE);
  assign r0a = reg_of(c_r, SUB_BLANKING_RED_GAIN);
  assign r0b = reg_of(c_r, SUB_GAIN_TEST_BLUE_GAIN);
  assign r0c = reg_of(c_r, SUB_OUTPUT_FORMAT_BRIGHTNESS);
  assign r0d = reg_of(c_r, SUB_CONTRAST_SETTING);
  assign r0e = reg_of(c_r, SUB_LUMA_FILTER_SHARPNESS);
  assign r0f = reg_of(c_r, SUB_HUE_SETTING);
  assign r10 = reg_of(c_r, SUB_SATURATION_SETTING);
  assign r11 = reg_of(c_r, SUB_VERTICAL_TEST_SELECT);
  assign r12 = reg_of(c_r, SUB_IF_VIDEO_AUDIO_LEVELS);
  assign r13 = reg_of(c_r, SUB_NOISE_AUDIO_VOLUME);

  // Test switches only act while the gate bit is zero; video mute only once it is one
  assign test_mode_enable = ~r00[DA4];
  assign video_mute = r00[DA6] & r00[DA4];
  assign sync_kill = r00[DA7];
  assign horiz_loop_speed = r01[DA4];
  assign horiz_phase = r01[DA5:DA7];
  assign gain_loop_defeat = r02[DA0];
  assign fine_tune_out_defeat = r02[DA1];
  assign tuner_gain_threshold = r02[DA2:DA7];
  assign picture_source_select = r03[DA0];
  assign vco_tune = r03[DA1:DA7];
  assign audio_mute = r04[DA1];
  assign crossover_trim = r04[DA2:DA7];
  assign vert_countdown_select = r05[DA0];
  assign vert_bias_trim = r05[DA2:DA7];
  assign vert_kill = r06[DA0];
  assign color_kill = r06[DA1];
  assign vert_amplitude = r06[DA2:DA7];
  assign red_dc = c_r.regs[SUB_RED_DC_LEVEL][DA1:DA7];
  assign green_dc = c_r.regs[SUB_GREEN_DC_LEVEL][DA1:DA7];
  assign blue_dc = c_r.regs[SUB_BLUE_DC_LEVEL][DA1:DA7];
  assign blanking_off = r0a[DA0];
  assign red_gain = r0a[DA1:DA7];
  assign drive_test = r0b[DA0] & ~r00[DA4];
  assign blue_gain = r0b[DA1:DA7];
  assign color_diff_mode = r0c[DA0];
  assign brightness = r0c[DA1:DA7];
  assign contrast_test = r0d[DA0] & ~r00[DA4];
  assign contrast = r0d[DA1:DA7];
  assign luma_filter_select = r0e[DA0];
  assign auto_flesh = r0e[DA1];
  assign dark_level_expand_defeat = r0e[DA2];
  assign sharpness = r0e[DA3:DA7];
  assign tint_test = r0f[DA0] & ~r00[DA4];
  assign tint = r0f[DA1:DA7];
  assign color_test = r10[DA0] & ~r00[DA4];
  assign color = r10[DA1:DA7];
  assign vert_size_test = (r11[DA5:DA7] != 3'h0) & ~r00[DA4];
  assign if_video_level = r12[DA0:DA2];
  assign wideband_sound_level = r12[DA3:DA7];
  assign noise_inverter_defeat = r13[DA0];
  assign sound_source_select = r13[DA1];
  assign volume = r13[DA2:DA7];

  ////////////////////////////////////////////////////////////////////////////////
  // Checks
  sequence s_take_sub(logic [4:0] s);
    take && l_sub == s;
  endsequence

  a_write_lands: assert property (@(posedge clock) disable iff (!rst_b)
    take && l_sub <= TVCRB_LAST_SUB |=> c_r.regs[$past(l_sub)] == ($past(l_data) & TVCRB_USED[$past(l_sub)]))
    else $error("written byte not stored");
  a_unused_zero: assert property (@(posedge clock) disable iff (!rst_b)
    (r00 & ~TVCRB_USED[0]) == 8'h00) else $error("unused bit stored");
  a_reg_stable: assert property (@(posedge clock) disable iff (!rst_b)
    !take |=> $stable(c_r.regs)) else $error("register changed without a write");
  a_mute_gated: assert property (@(posedge clock) disable iff (!rst_b)
    !r00[DA4] |-> !video_mute) else $error("video mute active in test mode");
  a_test_gated: assert property (@(posedge clock) disable iff (!rst_b)
    r00[DA4] |-> !(drive_test || contrast_test || tint_test || color_test)) else $error("test bit leaked");
  a_phase_update: assert property (@(posedge clock) disable iff (!rst_b)
    s_take_sub(SUB_HORIZ_LOOP_PHASE) |=> horiz_phase == $past(l_data[DA5:DA7])) else $error("phase not updated");
  a_volume_update: assert property (@(posedge clock) disable iff (!rst_b)
    s_take_sub(SUB_NOISE_AUDIO_VOLUME) |=> volume == $past(l_data[DA2:DA7]) ##0 noise_inverter_defeat == $past(l_data[DA0]))
    else $error("volume byte not split");
  a_levels_update: assert property (@(posedge clock) disable iff (!rst_b)
    s_take_sub(SUB_IF_VIDEO_AUDIO_LEVELS) |=> {if_video_level, wideband_sound_level} == $past(l_data))
    else $error("level byte not split");
  a_vsize_test: assert property (@(posedge clock) disable iff (!rst_b)
    vert_size_test |-> r11[DA5:DA7] != 3'h0) else $error("size test without field");
endmodule : tvcrb_top

/* bench/tvcrb_i2c_master.sv */
// Two-wire bus master that writes control bytes to the register bank.
// Assumes an open-drain data line with a pull-up, resolved by the testbench.
`timescale 1ns/1ns
module tvcrb_i2c_master (
  output logic scl,
  output logic sda_pull,
  input wire logic sda_line
);
  // Clock stands high outside frames; data is released until a frame starts
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus conditions, one 30 ns clock per bit
  task start_cond();
    if (scl === 1'b0) begin
      #7 sda_pull = 1'b0;
      #8 scl = 1'b1;
      #7;
    end
    sda_pull = 1'b1;
    #15 scl = 1'b0;
  endtask : start_cond

  task stop_cond();
    #7 sda_pull = 1'b1;
    #8 scl = 1'b1;
    #8 sda_pull = 1'b0;
    #7;
  endtask : stop_cond

  task put_bit(input logic b);
    #7 sda_pull = ~b;
    #8 scl = 1'b1;
    #15 scl = 1'b0;
  endtask : put_bit

  // Every byte goes out bit 7 first; in data bytes bit 7 is DA0
  task send_byte(input logic [7:0] b, output logic ack);
    for (int i = 0; i < 8; i++) begin
      put_bit(b[7 - i]);
    end
    #7 sda_pull = 1'b0;
    #8 scl = 1'b1;
    #7 ack = (sda_line === 1'b0);
    #8 scl = 1'b0;
  endtask : send_byte
endmodule : tvcrb_i2c_master

/* bench/test_tv_signal_control_register_bank.sv */
// Self-checking testbench for the control register bank top.
// Assumes the bus master model in tvcrb_i2c_master and a pull-up on the data line.
`timescale 1ns/1ns
module test_tv_signal_control_register_bank;
  import tvcrb_pkg::*;
  logic clock, rst_b, scl, sda_pull, sda_out, sda_oe;
  wire sda_line;
  logic test_mode_enable, video_mute, sync_kill, horiz_loop_speed, gain_loop_defeat, fine_tune_out_defeat;
  logic picture_source_select, audio_mute, vert_countdown_select, vert_kill, color_kill, blanking_off;
  logic drive_test, color_diff_mode, contrast_test, luma_filter_select, auto_flesh, dark_level_expand_defeat;
  logic tint_test, color_test, vert_size_test, noise_inverter_defeat, sound_source_select;
  logic [2:0] horiz_phase, if_video_level;
  logic [4:0] sharpness, wideband_sound_level;
  logic [5:0] tuner_gain_threshold, crossover_trim, vert_bias_trim, vert_amplitude, volume;
  logic [6:0] vco_tune, red_dc, green_dc, blue_dc, red_gain, blue_gain, brightness, contrast, tint, color;
  logic [7:0] r [TVCRB_NUM_REGS];
  logic [7:0] pend [$];
  logic [15:0] bad [4] = '{16'hB800, 16'hBB00, 16'hBA14, 16'hBA1F};
  int mismatches = 0;
  int checks = 0;

  // Open-drain line: low if either party pulls, pull-up otherwise
  assign sda_line = (sda_pull || (sda_oe && !sda_out)) ? 1'b0 : 1'b1;

  tvcrb_top dut (.clock, .rst_b, .scl, .sda_in(sda_line), .sda_out, .sda_oe, .test_mode_enable, .video_mute,
    .sync_kill, .horiz_loop_speed, .horiz_phase, .gain_loop_defeat, .fine_tune_out_defeat, .tuner_gain_threshold,
    .picture_source_select, .vco_tune, .audio_mute, .crossover_trim, .vert_countdown_select, .vert_bias_trim,
    .vert_kill, .color_kill, .vert_amplitude, .red_dc, .green_dc, .blue_dc, .blanking_off, .red_gain, .drive_test,
    .blue_gain, .color_diff_mode, .brightness, .contrast_test, .contrast, .luma_filter_select, .auto_flesh,
    .dark_level_expand_defeat, .sharpness, .tint_test, .tint, .color_test, .color, .vert_size_test,
    .if_video_level, .wideband_sound_level, .noise_inverter_defeat, .sound_source_select, .volume);

  tvcrb_i2c_master u_master (.scl(scl), .sda_pull(sda_pull), .sda_line(sda_line));

  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Comparison, verdict and field checks
  task check(input logic [23:0] seen, input logic [23:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task complete_run();
    $display("checks=%0d mismatches=%0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : complete_run

  task check_all();
    logic g;
    g = r[0][DA4];
    check({test_mode_enable, video_mute, sync_kill}, {~g, r[0][DA6] & g, r[0][DA7]});
    check({horiz_loop_speed, horiz_phase}, {r[1][DA4], r[1][DA5:DA7]});
    check({gain_loop_defeat, fine_tune_out_defeat, tuner_gain_threshold},
      {r[2][DA0], r[2][DA1], r[2][DA2:DA7]});
    check({picture_source_select, vco_tune}, {r[3][DA0], r[3][DA1:DA7]});
    check({audio_mute, crossover_trim}, {r[4][DA1], r[4][DA2:DA7]});
    check({vert_countdown_select, vert_bias_trim}, {r[5][DA0], r[5][DA2:DA7]});
    check({vert_kill, color_kill, vert_amplitude}, {r[6][DA0], r[6][DA1], r[6][DA2:DA7]});
    check({red_dc, green_dc, blue_dc}, {r[7][DA1:DA7], r[8][DA1:DA7], r[9][DA1:DA7]});
    check({blanking_off, red_gain}, {r[10][DA0], r[10][DA1:DA7]});
    check({drive_test, blue_gain}, {r[11][DA0] & ~g, r[11][DA1:DA7]});
    check({color_diff_mode, brightness}, {r[12][DA0], r[12][DA1:DA7]});
    check({contrast_test, contrast}, {r[13][DA0] & ~g, r[13][DA1:DA7]});
    check({luma_filter_select, auto_flesh, dark_level_expand_defeat, sharpness},
      {r[14][DA0], r[14][DA1], r[14][DA2], r[14][DA3:DA7]});
    check({tint_test, tint, color_test, color},
      {r[15][DA0] & ~g, r[15][DA1:DA7], r[16][DA0] & ~g, r[16][DA1:DA7]});
    check({vert_size_test, if_video_level, wideband_sound_level},
      {(r[17][DA5:DA7] != 3'h0) & ~g, r[18][DA0:DA2], r[18][DA3:DA7]});
    check({noise_inverter_defeat, sound_source_select, volume},
      {r[19][DA0], r[19][DA1], r[19][DA2:DA7]});
  endtask : check_all

  ////////////////////////////////////////////////////////////////////////////
  // One frame: address, sub-address, then the queued data bytes
  task do_write(input logic [7:0] ab, input logic [7:0] sub, input logic stp);
    logic ack;
    logic ok;
    logic [7:0] d;
    int k;
    ok = (ab === {TVCRB_SLAVE_ADDR, 1'b0});
    @(posedge clock);
    #1 u_master.start_cond();
    u_master.send_byte(ab, ack);
    check({23'h0, ack}, {23'h0, ok});
    if (ok) begin
      u_master.send_byte(sub, ack);
      ok = (sub <= {3'h0, TVCRB_LAST_SUB});
      check({23'h0, ack}, {23'h0, ok});
    end
    k = sub;
    while (ok && pend.size() > 0) begin
      d = pend.pop_front() & TVCRB_USED[k];
      u_master.send_byte(d, ack);
      check({23'h0, ack}, 24'h1);
      r[k] = d;
      k = (k == TVCRB_NUM_REGS - 1) ? 0 : k + 1;
    end
    pend.delete();
    if (stp) u_master.stop_cond();
    repeat (10) @(posedge clock);
  endtask : do_write

  task do_reset();
    @(posedge clock);
    #1 rst_b = 1'b0;
    repeat (10) @(posedge clock);
    #1 rst_b = 1'b1;
    repeat (4) @(posedge clock);
    r = TVCRB_RESET;
    check_all();
    // Initial phase and tuning values read with DA-low as the field MSB
    check({14'h0, horiz_phase, vco_tune}, {14'h0, 3'h4, 7'h40});
  endtask : do_reset

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    rst_b = 1'b0;
    do_reset();
    pend = '{8'h0A};
    do_write(8'hBA, 8'h00, 1'b1);
    check_all();
    pend = '{8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h07};
    do_write(8'hBA, 8'h0B, 1'b1);
    check_all();
    pend = '{8'h01};
    do_write(8'hBA, 8'h00, 1'b1);
    check_all();
    for (int p = 0; p < 2; p++) begin
      for (int i = 0; i < 22; i++) begin
        pend.push_back((8'(i * 29) ^ 8'hA5) ^ {8{p[0]}});
      end
      do_write(8'hBA, 8'h12, 1'b1);
      check_all();
    end
    for (int i = 0; i < 4; i++) begin
      pend = '{8'hFF, 8'hFF};
      do_write(bad[i][15:8], bad[i][7:0], 1'b1);
      check_all();
    end
    pend = '{8'h3C};
    do_write(8'hBA, 8'h13, 1'b0);
    pend = '{8'hC5, 8'h6A};
    do_write(8'hBA, 8'h05, 1'b1);
    check_all();
    do_reset();
    complete_run();
  end

  initial begin
    repeat (100000) @(posedge clock);
    mismatches++;
    complete_run();
  end
endmodule : test_tv_signal_control_register_bank
